// ==== rtl/sbsram_consts.svh ====
`ifndef SBSRAM_CONSTS_SVH
`define SBSRAM_CONSTS_SVH
// Default geometry, kept small so a model stays cheap
`define SBSRAM_ADDR_W 10
`define SBSRAM_BYTES 4
`define SBSRAM_BYTE_W 9
// Read latency in cycles from command edge to data edge
`define SBSRAM_PIPE_LAT 2
`define SBSRAM_FLOW_LAT 1
`define SBSRAM_TAP_IR_W 2
`define SBSRAM_TAP_BYPASS 2'h3
`define SBSRAM_TAP_IDCODE 2'h1
// Identity value is arbitrary and names no maker
`define SBSRAM_TAP_ID_VALUE 32'h00000001
`endif

// ==== rtl/sbsram_pkg.sv ====
package sbsram_pkg;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UP_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UP_IR = 16'h8000
  } sbsram_tap_t;
endpackage

// ==== rtl/sbsram_core.sv ====
// Functional notes
// R01 - Inputs captured only on rising clock edge
// R02 - Back-to-back reads and writes, no idle
// R03 - Host keeps burst order select static
// R04 - Sleep and output enable act asynchronously
// R05 - Output enable low-active override floats outputs
// R06 - Write started by edge, internally timed
// R07 - Static input picks pipelined or flow-through
// R08 - Pipelined read data held in output register
// R09 - Burst latencies 3-1-1-1 and 2-1-1-1
// R10 - Write data late by two or one
// R11 - Per-byte writes, nine-bit bytes, lane enables
// R12 - Three chip selects must all be active
// R13 - Sleep request enters low-power state
// R14 - Burst order select: linear or interleaved
// R15 - Boundary-scan test access port provided
// R16 - Clock gate high freezes state and outputs
// R17 - Flow-through select low selects flow-through
// R18 - Two selects active low, one high
// R19 - Burst step advances internal counter
// R20 - Counter wraps mod four or XOR order
// R21 - Host drives write strobe low for writes
// R22 - Reads see pending late-write data
`include "sbsram_consts.svh"
module sbsram_core #(
  parameter int ADDR_W = `SBSRAM_ADDR_W,
  parameter int BYTES = `SBSRAM_BYTES,
  parameter int BYTE_W = `SBSRAM_BYTE_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  // Command
  input wire logic clock_gate_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic write_n,
  input wire logic [BYTES-1:0] byte_write_n,
  input wire logic burst_step,
  input wire logic chip_select_low_first,
  input wire logic chip_select_high,
  input wire logic chip_select_low_second,
  // Static modes and async controls
  input wire logic flow_thru_select_n,
  input wire logic burst_order_select_n,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  // Data pins, split
  input wire logic [BYTES*BYTE_W-1:0] dq_in,
  output logic [BYTES*BYTE_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic sleeping,
  // Scan port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n
);
  localparam int DW = BYTES * BYTE_W;

  // ******************************************************
  // Command decode and burst counter
  // ******************************************************
  wire logic [DW-1:0] arr_word;
  logic run;
  logic sel;
  logic pipe_mode;
  logic [ADDR_W-1:0] base_r;
  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [ADDR_W-1:0] cur_addr;
  logic burst_sel_r;
  logic burst_wr_r;
  logic [BYTES-1:0] burst_be_r;

  assign run = ~clock_gate_n & ~sleep_request; // R16 R13
  assign sel = ~chip_select_low_first & chip_select_high &
               ~chip_select_low_second; // R12 R18
  assign pipe_mode = flow_thru_select_n; // R07 R17
  assign sleeping = sleep_request; // R04 R13

  // Linear wraps modulo four; interleaved walks by XOR with the step count
  always_comb begin
    if (!burst_order_select_n) begin
      cnt_nxt = cnt_r + 2'h1; // R14 R20
    end else begin
      cnt_nxt = (((cnt_r ^ start_r) + 2'h1) ^ start_r); // R20
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      base_r <= '0;
      start_r <= 2'h0;
      cnt_r <= 2'h0;
      burst_sel_r <= 1'b0;
      burst_wr_r <= 1'b0;
      burst_be_r <= '1;
    end else if (run) begin // R01
      if (burst_step) begin
        cnt_r <= cnt_nxt; // R19
      end else begin
        base_r <= addr;
        start_r <= addr[1:0]; // R20
        cnt_r <= addr[1:0];
        burst_sel_r <= sel;
        burst_wr_r <= ~write_n; // R21
        burst_be_r <= byte_write_n;
      end
    end
  end

  // Decode of this cycle, continuing a burst when stepping
  logic cyc_sel;
  logic cyc_wr;
  logic [BYTES-1:0] cyc_be;
  logic [ADDR_W-1:0] cyc_addr;
  assign cur_addr = {base_r[ADDR_W-1:2], cnt_nxt};
  assign cyc_sel = burst_step ? burst_sel_r : sel;
  assign cyc_wr = burst_step ? burst_wr_r : ~write_n;
  assign cyc_be = burst_step ? burst_be_r : byte_write_n;
  assign cyc_addr = burst_step ? cur_addr : addr;

  // ******************************************************
  // Late-write and read pipelines
  // ******************************************************
  // Stage 1 and 2 hold command info; write data lands 1 or 2 edges later
  logic [1:0] v_r;
  logic [1:0] w_r;
  logic [BYTES-1:0] be_r [0:1];
  logic [ADDR_W-1:0] a_r [0:1];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      v_r <= 2'h0;
      w_r <= 2'h0;
      be_r[0] <= '1;
      be_r[1] <= '1;
      a_r[0] <= '0;
      a_r[1] <= '0;
    end else if (run) begin // R02
      v_r <= {v_r[0], cyc_sel};
      w_r <= {w_r[0], cyc_wr};
      be_r[0] <= cyc_be;
      be_r[1] <= be_r[0];
      a_r[0] <= cyc_addr;
      a_r[1] <= a_r[0];
    end
  end

  // Stage whose data is on the bus now
  logic dat_v;
  logic dat_w;
  logic [BYTES-1:0] dat_be;
  logic [ADDR_W-1:0] dat_a;
  assign dat_v = pipe_mode ? v_r[1] : v_r[0]; // R10
  assign dat_w = pipe_mode ? w_r[1] : w_r[0];
  assign dat_be = pipe_mode ? be_r[1] : be_r[0];
  assign dat_a = pipe_mode ? a_r[1] : a_r[0];

  // Array write, completed inside the edge, no external pulse; each lane
  // keeps its own array so that no two processes write one variable
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : g_lane
      logic [BYTE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
      always_ff @(posedge clk_sys) begin
        if (run && dat_v && dat_w && !dat_be[g]) begin // R06 R11
          lane_mem[dat_a] <= dq_in[g*BYTE_W +: BYTE_W];
        end
      end
      assign arr_word[g*BYTE_W +: BYTE_W] = lane_mem[dat_a];
    end
  endgenerate

  // Reads touch the array in the same late slot in which writes land, so
  // every earlier write, even one issued just before, is already stored
  // Array access happens when the read's data slot arrives
  logic [DW-1:0] q_r;
  logic drive_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_r <= '0;
      drive_r <= 1'b0;
    end else if (run) begin
      drive_r <= dat_v & ~dat_w; // R09
      if (dat_v && !dat_w) begin
        q_r <= arr_word; // R08 R22
      end
    end
  end

  // Flow mode: word available one edge after command, pipe: two
  assign dq_out = q_r; // R09
  assign dq_oe_n = ~(drive_r & ~output_enable_n & ~sleep_request); // R04 R05

  // ******************************************************
  // Boundary-scan port (bypass and id)
  // ******************************************************
  sbsram_pkg::sbsram_tap_t tap_r;
  sbsram_pkg::sbsram_tap_t tap_nxt;
  logic [`SBSRAM_TAP_IR_W-1:0] ir_r;
  logic [`SBSRAM_TAP_IR_W-1:0] irsh_r;
  logic [31:0] drsh_r;
  logic tdo_r;

  always_comb begin
    case (tap_r)
      sbsram_pkg::TAP_RESET:
        tap_nxt = tms ? sbsram_pkg::TAP_RESET : sbsram_pkg::TAP_IDLE;
      sbsram_pkg::TAP_IDLE:
        tap_nxt = tms ? sbsram_pkg::TAP_SEL_DR : sbsram_pkg::TAP_IDLE;
      sbsram_pkg::TAP_SEL_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_SEL_IR : sbsram_pkg::TAP_CAP_DR;
      sbsram_pkg::TAP_CAP_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX1_DR : sbsram_pkg::TAP_SH_DR;
      sbsram_pkg::TAP_SH_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX1_DR : sbsram_pkg::TAP_SH_DR;
      sbsram_pkg::TAP_EX1_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_UP_DR : sbsram_pkg::TAP_PA_DR;
      sbsram_pkg::TAP_PA_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX2_DR : sbsram_pkg::TAP_PA_DR;
      sbsram_pkg::TAP_EX2_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_UP_DR : sbsram_pkg::TAP_SH_DR;
      sbsram_pkg::TAP_UP_DR:
        tap_nxt = tms ? sbsram_pkg::TAP_SEL_DR : sbsram_pkg::TAP_IDLE;
      sbsram_pkg::TAP_SEL_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_RESET : sbsram_pkg::TAP_CAP_IR;
      sbsram_pkg::TAP_CAP_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX1_IR : sbsram_pkg::TAP_SH_IR;
      sbsram_pkg::TAP_SH_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX1_IR : sbsram_pkg::TAP_SH_IR;
      sbsram_pkg::TAP_EX1_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_UP_IR : sbsram_pkg::TAP_PA_IR;
      sbsram_pkg::TAP_PA_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_EX2_IR : sbsram_pkg::TAP_PA_IR;
      sbsram_pkg::TAP_EX2_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_UP_IR : sbsram_pkg::TAP_SH_IR;
      sbsram_pkg::TAP_UP_IR:
        tap_nxt = tms ? sbsram_pkg::TAP_SEL_DR : sbsram_pkg::TAP_IDLE;
      default: tap_nxt = sbsram_pkg::TAP_RESET;
    endcase
  end

  // Scan clock sampled as a plain input; its rising edge is an enable
  logic tck_d_r;
  logic tck_rise;
  logic tck_fall;
  assign tck_rise = tck & ~tck_d_r;
  assign tck_fall = ~tck & tck_d_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tck_d_r <= 1'b0;
      tap_r <= sbsram_pkg::TAP_RESET;
      ir_r <= `SBSRAM_TAP_IDCODE;
      irsh_r <= '0;
      drsh_r <= '0;
      tdo_r <= 1'b0;
    end else begin
      tck_d_r <= tck;
      if (tck_rise) begin // R15
        tap_r <= tap_nxt;
        case (tap_r)
          sbsram_pkg::TAP_RESET: ir_r <= `SBSRAM_TAP_IDCODE;
          sbsram_pkg::TAP_CAP_IR: irsh_r <= 2'h1;
          sbsram_pkg::TAP_SH_IR: irsh_r <= {tdi, irsh_r[1]};
          sbsram_pkg::TAP_UP_IR: ir_r <= irsh_r;
          sbsram_pkg::TAP_CAP_DR: drsh_r <= (ir_r == `SBSRAM_TAP_IDCODE) ?
                                           `SBSRAM_TAP_ID_VALUE : 32'h0;
          sbsram_pkg::TAP_SH_DR: begin
            if (ir_r == `SBSRAM_TAP_IDCODE) begin
              drsh_r <= {tdi, drsh_r[31:1]};
            end else begin
              drsh_r <= {31'h0, tdi};
            end
          end
          default: ;
        endcase
      end
      if (tck_fall) begin
        tdo_r <= (tap_r == sbsram_pkg::TAP_SH_IR) ? irsh_r[0] : drsh_r[0];
      end
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe_n = ~((tap_r == sbsram_pkg::TAP_SH_DR) ||
                      (tap_r == sbsram_pkg::TAP_SH_IR));
endmodule // sbsram_core

// ==== verif/sbsram_core_assertions.sv ====
module sbsram_checker #(
  parameter int BYTES = 4,
  parameter int BYTE_W = 9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Command and modes
  input wire logic clock_gate_n,
  input wire logic write_n,
  input wire logic burst_step,
  input wire logic chip_select_low_first,
  input wire logic chip_select_high,
  input wire logic chip_select_low_second,
  input wire logic flow_thru_select_n,
  input wire logic sleep_request,
  input wire logic output_enable_n,
  // Outputs
  input wire logic [BYTES*BYTE_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic sleeping
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic run;
  logic cmd;
  // An edge only counts when neither the gate nor sleep froze it
  assign run = !clock_gate_n && !sleep_request;
  assign cmd = run && !burst_step && !chip_select_low_first
    && chip_select_high && !chip_select_low_second;
  // ****************************************
  // Properties
  // ****************************************
  sequence s_two;
    run ##1 run;
  endsequence
  sequence s_wr_pipe;
    cmd && !write_n && flow_thru_select_n ##1 s_two;
  endsequence
  property p_read_pipe;
    cmd && write_n && flow_thru_select_n ##1 s_two
      |=> output_enable_n || sleep_request || !dq_oe_n;
  endproperty
  property p_read_flow;
    cmd && write_n && !flow_thru_select_n ##1 run
      |=> output_enable_n || sleep_request || !dq_oe_n;
  endproperty
  property p_write_quiet;
    s_wr_pipe |=> dq_oe_n;
  endproperty
  property p_desel;
    run && !burst_step && chip_select_low_first && flow_thru_select_n
      ##1 s_two |=> dq_oe_n;
  endproperty
  property p_oe;
    output_enable_n |-> dq_oe_n;
  endproperty
  property p_sleep_float;
    sleep_request |-> dq_oe_n && sleeping;
  endproperty
  property p_gate_hold;
    clock_gate_n [*2] |-> $stable(dq_out);
  endproperty
  property p_sleep_hold;
    sleep_request ##1 sleep_request |-> $stable(dq_out);
  endproperty
  a_read_pipe: assert property (p_read_pipe)
    else $error("pipelined read not driven");
  a_read_flow: assert property (p_read_flow)
    else $error("flow-through read not driven");
  a_write_quiet: assert property (p_write_quiet)
    else $error("write slot driven");
  a_desel: assert property (p_desel)
    else $error("deselected read driven");
  a_oe: assert property (p_oe)
    else $error("outputs driven with enable off");
  a_sleep_float: assert property (p_sleep_float)
    else $error("outputs driven in sleep");
  a_gate_hold: assert property (p_gate_hold)
    else $error("data changed while gated");
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("data changed while asleep");
endmodule // sbsram_checker

bind sbsram_core sbsram_checker #(.BYTES(BYTES), .BYTE_W(BYTE_W))
  sbsram_checker_i (.clk_sys, .reset, .clock_gate_n, .write_n, .burst_step,
  .chip_select_low_first, .chip_select_high, .chip_select_low_second,
  .flow_thru_select_n, .sleep_request, .output_enable_n, .dq_out, .dq_oe_n,
  .sleeping);

// ==== verif/sbsram_host.sv ====
module sbsram_host (
  // Clock and mode
  input wire logic clk_sys,
  input wire logic flow_thru_select_n,
  // Command
  output logic [9:0] addr,
  output logic write_n,
  output logic [3:0] byte_write_n,
  output logic burst_step,
  output logic chip_select_low_first,
  output logic chip_select_high,
  output logic chip_select_low_second,
  // Late write data
  output logic [35:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] wd0 = 36'h0;
  logic [35:0] wd1 = 36'h0;
  logic [35:0] wd2 = 36'h0;
  initial begin
    {addr, write_n, byte_write_n, burst_step} = {10'h0, 1'b1, 4'hf, 1'b0};
    {chip_select_low_first, chip_select_high, chip_select_low_second} = 3'h5;
  end
  // ****************************************
  // Late write data
  // ****************************************
  // Data trails its command by one or two edges, hence a delay line
  always @(posedge clk_sys) begin
    wd1 <= wd0;
    wd2 <= wd1;
  end
  assign dq_in = flow_thru_select_n ? wd2 : wd1;
  task automatic op(input logic [9:0] a, input logic wr, input logic [3:0] be,
    input logic step, input logic [2:0] cs, input logic [35:0] wd);
    @(posedge clk_sys);
    #1;
    addr = a;
    write_n = !wr;
    byte_write_n = wr ? be : 4'hf;
    burst_step = step;
    {chip_select_low_first, chip_select_high, chip_select_low_second} = cs;
    // No write data: inverse of the last word, so nothing stale looks valid
    wd0 = wr ? wd : ~wd0;
  endtask
endmodule // sbsram_host

// ==== verif/sbsram_core_tb.sv ====
`include "sbsram_consts.svh"
module sbsram_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clock_gate_n = 1'b0;
  logic flow_thru_select_n = 1'b1;
  logic burst_order_select_n = 1'b0;
  logic sleep_request = 1'b0;
  logic output_enable_n = 1'b0;
  logic [9:0] addr;
  logic write_n;
  logic burst_step;
  logic [3:0] byte_write_n;
  logic chip_select_low_first;
  logic chip_select_high;
  logic chip_select_low_second;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic dq_oe_n;
  logic sleeping;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdo;
  logic tdo_oe_n;
  logic [35:0] mem [1024];
  logic [35:0] exp_q[$];
  int due_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  sbsram_core sbsram_core_i (.clk_sys, .reset, .clock_gate_n, .addr,
    .write_n, .byte_write_n, .burst_step, .chip_select_low_first,
    .chip_select_high, .chip_select_low_second, .flow_thru_select_n,
    .burst_order_select_n, .sleep_request, .output_enable_n, .dq_in, .dq_out,
    .dq_oe_n, .sleeping, .tck, .tms, .tdi(1'b0), .tdo,
    .tdo_oe_n);
  sbsram_host host_i (.clk_sys, .flow_thru_select_n, .addr, .write_n,
    .byte_write_n, .burst_step, .chip_select_low_first, .chip_select_high,
    .chip_select_low_second, .dq_in);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Scoreboard
  // ****************************************
  // Read data is judged on the edge that closes its one-cycle slot
  always @(posedge clk_sys) begin
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      chk({35'h0, dq_oe_n}, 36'h0);
      chk(dq_out, exp_q[0]);
      void'(due_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic wr(input logic [9:0] a, input logic [3:0] be,
    input logic [35:0] d);
    host_i.op(a, 1'b1, be, 1'b0, 3'b010, d);
    for (int b = 0; b < 4; b++)
      if (!be[b]) mem[a][b*9 +: 9] = d[b*9 +: 9];
  endtask
  task automatic rd(input logic [9:0] a, input logic step);
    host_i.op(a, 1'b0, 4'hf, step, 3'b010, 36'h0);
    due_q.push_back(cyc + 1 + (flow_thru_select_n ? `SBSRAM_PIPE_LAT
      : `SBSRAM_FLOW_LAT));
    exp_q.push_back(mem[a]);
  endtask
  task automatic idle(input int n);
    repeat (n) host_i.op(10'h0, 1'b0, 4'hf, 1'b0, 3'b101, 36'h0);
  endtask
  task automatic restart(input logic ft_n, input logic lbo_n);
    @(posedge clk_sys);
    #1 reset = 1'b1;
    flow_thru_select_n = ft_n;
    burst_order_select_n = lbo_n;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_rw(input logic ft_n);
    restart(ft_n, 1'b0);
    wr(10'h010, 4'h0, 36'h123456789);
    wr(10'h011, 4'h0, 36'hfedcba987);
    rd(10'h010, 1'b0);
    wr(10'h010, 4'ha, 36'h0a5a5a5a5);
    rd(10'h010, 1'b0);
    rd(10'h011, 1'b0);
    idle(5);
  endtask
  task automatic sc_burst(input logic lbo_n);
    restart(1'b1, lbo_n);
    for (int i = 0; i < 4; i++)
      wr(10'h020 + 10'(i), 4'h0, 36'(i + 1) * 36'h111111111);
    // Starting at 1 the two orders differ in the second and fourth beats
    rd(10'h021, 1'b0);
    for (int k = 1; k < 4; k++)
      rd(lbo_n ? 10'h020 | 10'(1 ^ k)
        : 10'h020 | 10'((1 + k) % 4), 1'b1);
    idle(5);
  endtask
  task automatic sc_sel_gate;
    restart(1'b1, 1'b0);
    wr(10'h030, 4'h0, 36'h0c0c0c0c0);
    wr(10'h040, 4'h0, 36'h0aaaa5555);
    for (int i = 0; i < 3; i++)
      host_i.op(10'h030, 1'b1, 4'h0, 1'b0, 3'b010 ^ 3'(1 << i), 36'h0);
    rd(10'h030, 1'b0);
    idle(4);
    host_i.op(10'h040, 1'b1, 4'h0, 1'b0, 3'b010, 36'h0);
    clock_gate_n = 1'b1;
    host_i.op(10'h040, 1'b1, 4'h0, 1'b0, 3'b010, 36'h0);
    idle(1);
    clock_gate_n = 1'b0;
    rd(10'h040, 1'b0);
    idle(5);
  endtask
  task automatic sc_async;
    host_i.op(10'h040, 1'b0, 4'hf, 1'b0, 3'b010, 36'h0);
    host_i.op(10'h040, 1'b0, 4'hf, 1'b0, 3'b010, 36'h0);
    idle(1);
    @(posedge clk_sys);
    #2 chk(dq_out, 36'h0aaaa5555);
    output_enable_n = 1'b1;
    #1 chk({35'h0, dq_oe_n}, 36'h1);
    // Held across an edge while the first read is due, so the checker
    // sees the override with data waiting
    @(posedge clk_sys);
    #2 chk(dq_out, 36'h0aaaa5555);
    output_enable_n = 1'b0;
    #1 chk({35'h0, dq_oe_n}, 36'h0);
    sleep_request = 1'b1;
    #1 chk({34'h0, sleeping, dq_oe_n}, 36'h3);
    idle(2);
    sleep_request = 1'b0;
    idle(3);
  endtask
  // Scan clock kept well below a quarter of the system clock
  task automatic scan_clk(input logic t, output logic o);
    tms = t;
    repeat (3) @(posedge clk_sys);
    #1 tck = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 tck = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 o = tdo;
  endtask
  task automatic sc_scan;
    logic o;
    logic [31:0] id;
    id = 32'h0;
    // Idle, select, capture, then 32 clocks, the first entering shift and the last leaving it
    scan_clk(1'b0, o);
    scan_clk(1'b1, o);
    scan_clk(1'b0, o);
    chk({35'h0, tdo_oe_n}, 36'h1);
    for (int i = 0; i < 32; i++) begin
      scan_clk(i == 31, o);
      id[i] = o;
      chk({35'h0, tdo_oe_n}, {35'h0, i == 31});
    end
    chk({4'h0, id}, {4'h0, `SBSRAM_TAP_ID_VALUE});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    for (int m = 0; m < 2; m++) sc_rw(m[0]);
    for (int m = 0; m < 2; m++) sc_burst(m[0]);
    sc_sel_gate();
    sc_async();
    sc_scan();
    chk(36'(due_q.size()), 36'h0);
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
endmodule // sbsram_core_tb
